// >>> rtl/flash_query_regs.svh
`ifndef FLASH_QUERY_REGS_SVH
`define FLASH_QUERY_REGS_SVH
// Command codes on the flash data bus
`define CMD_QUERY          8'h98
`define CMD_SIGNATURE      8'h90
`define CMD_READ_STATUS    8'h70
`define CMD_CLEAR_STATUS   8'h50
`define CMD_READ_ARRAY     8'hff
`define CMD_PROGRAM        8'h40
`define CMD_BUFFER_PROGRAM 8'he8
`define CMD_CONFIRM        8'hd0
`define CMD_SUSPEND        8'hb0
// Query space
`define QRY_POINTER_OFFSET 9'h015
`define QRY_POINTER_VALUE  9'h10a
`define QRY_REGION1_REL    9'h024
// Status bit positions
`define SR_READY_BIT       7
`define SR_SUSPEND_BIT     6
`define SR_FAIL_BIT        4
`define SR_VPP_BIT         3
`define SR_PROT_BIT        1
// Controller registers on AXI4-Lite (byte addresses)
`define REG_CONTROL        4'h0
`define REG_ADDRESS        4'h4
`define REG_DATA           4'h8
`define REG_STATUS         4'hc
// Controller operation codes in control[2:0]
`define OP_QUERY           3'h1
`define OP_PROGRAM         3'h2
`define OP_STATUS          3'h3
`define OP_CLEAR           3'h4
`define OP_SUSPEND         3'h5
`define OP_RESUME          3'h6
`define OP_BUFFER          3'h7
// Device busy time for a program, in cycles
`define PROGRAM_BUSY_CYCLES 8'h10
`endif

// >>> rtl/flash_query_pkg.sv
package flash_query_pkg;
  typedef enum logic [1:0] {
    mode_array  = 2'b00,
    mode_query  = 2'b01,
    mode_status = 2'b11
  } read_mode_type;
  typedef enum logic [2:0] {
    host_idle   = 3'b000,
    host_cmd    = 3'b001,
    host_data   = 3'b011,
    host_read   = 3'b010,
    host_done   = 3'b110
  } host_state_type;
endpackage : flash_query_pkg

// >>> rtl/flash_link_if.sv
`timescale 1ns/100ps
interface flash_link_if;
  logic        we;
  logic        re;
  logic [22:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  modport device (input we, re, addr, wdata, output rdata, rvalid);
  modport host (output we, re, addr, wdata, input rdata, rvalid);
endinterface : flash_link_if

// >>> rtl/query_rom.sv
`timescale 1ns/100ps
`include "flash_query_regs.svh"
module query_rom
(
  // Variant and offset
  input  wire logic       top_boot,
  input  wire logic [8:0] offset,
  // Byte out
  output logic [7:0]      data
);
  // Pointer is wider than a byte; low byte first, high byte next
  localparam logic [8:0] pointer_value = `QRY_POINTER_VALUE;

  // Fixed per variant, no write path at all
  always_comb
  begin
    data = 8'h00;
    if (offset == `QRY_POINTER_OFFSET)
      data = pointer_value[7:0];
    else if (offset == `QRY_POINTER_OFFSET + 9'h001)
      data = {7'h00, pointer_value[8]};
    else if (offset == 9'h12d)
      data = 8'h02;
    else if (offset == 9'h12e)
      data = top_boot ? 8'h0f : 8'h01;
    else if (offset == 9'h130)
      data = 8'h11;
    else if (offset == 9'h131 || offset == 9'h132)
      data = 8'h00;
    else if (offset == 9'h133)
      data = top_boot ? 8'h01 : 8'h02;
    else if (top_boot)
    begin
      unique case (offset)
        9'h134: data = 8'h0f;
        9'h137: data = 8'h02;
        9'h138: data = 8'h64;
        9'h13a: data = 8'h02;
        9'h13b: data = 8'h03;
        9'h13c: data = 8'h01;
        9'h13e: data = 8'h11;
        9'h141: data = 8'h02;
        9'h142: data = 8'h0e;
        9'h145: data = 8'h02;
        9'h146: data = 8'h64;
        9'h148: data = 8'h02;
        9'h149: data = 8'h03;
        9'h14a: data = 8'h03;
        9'h14c: data = 8'h80;
        9'h14e: data = 8'h64;
        9'h150: data = 8'h02;
        9'h151: data = 8'h03;
        default: data = 8'h00;
      endcase
    end
    else
    begin
      unique case (offset)
        9'h134: data = 8'h03;
        9'h136: data = 8'h80;
        9'h138: data = 8'h64;
        9'h13a: data = 8'h02;
        9'h13b: data = 8'h03;
        9'h13c: data = 8'h0e;
        9'h13f: data = 8'h02;
        9'h140: data = 8'h64;
        9'h142: data = 8'h02;
        9'h143: data = 8'h03;
        9'h144: data = 8'h0f;
        9'h146: data = 8'h11;
        9'h149: data = 8'h01;
        9'h14a: data = 8'h0f;
        9'h14d: data = 8'h02;
        9'h14e: data = 8'h64;
        9'h150: data = 8'h02;
        9'h151: data = 8'h03;
        default: data = 8'h00;
      endcase
    end
  end
endmodule : query_rom

// >>> rtl/flash_device_end.sv
`timescale 1ns/100ps
`include "flash_query_regs.svh"
module flash_device_end
(
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // Link
  flash_link_if.device         link,
  // Variant strap and error injection
  input  wire logic            top_boot,
  input  wire logic            vpp_low,
  input  wire logic            block_protected,
  // Visible state
  output logic                 busy,
  output logic [7:0]           status
);
  logic [7:0] rom_byte;
  flash_query_pkg::read_mode_type mode;
  logic [7:0] busy_cnt;
  logic       suspended;
  logic       program_setup;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic       vpp_bad;
  logic       prot_bad;
  logic       buffer_setup;
  logic [4:0] buffer_left;
  logic       buffer_armed;
  logic       data_cycle;

  // Strap and error pins are asynchronous; two flops before any use
  always_ff @(posedge aclk)
  begin
    pin_meta <= {top_boot, vpp_low, block_protected};
    pin_sync <= pin_meta;
  end
  assign vpp_bad  = pin_sync[1];
  assign prot_bad = pin_sync[0];

  // Words that are payload, never decoded as commands
  assign data_cycle = program_setup || buffer_setup ||
                      buffer_left != 5'h00 || buffer_armed;

  query_rom rom (
    .top_boot (pin_sync[2]),
    .offset   (link.addr[8:0]),
    .data     (rom_byte)
  );

  // Read mode; command decode ignores the bank address bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode <= flash_query_pkg::mode_array;
    else if (link.we && !data_cycle)
    begin
      if (link.wdata[7:0] == `CMD_QUERY ||
          link.wdata[7:0] == `CMD_SIGNATURE)
        mode <= flash_query_pkg::mode_query;
      else if (link.wdata[7:0] == `CMD_READ_STATUS)
        mode <= flash_query_pkg::mode_status;
      else if (link.wdata[7:0] == `CMD_READ_ARRAY)
        mode <= flash_query_pkg::mode_array;
    end
  end

  // Program and buffer sequences, suspend with B0h and resume with D0h
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      program_setup <= 1'b0;
      buffer_setup  <= 1'b0;
      buffer_left   <= 5'h00;
      buffer_armed  <= 1'b0;
      busy_cnt      <= 8'h00;
      suspended     <= 1'b0;
    end
    else
    begin
      if (busy_cnt != 8'h00 && !suspended)
        busy_cnt <= busy_cnt - 8'h01;
      if (link.we)
      begin
        if (program_setup)
        begin
          program_setup <= 1'b0;
          if (!vpp_bad && !prot_bad)
            busy_cnt <= `PROGRAM_BUSY_CYCLES;
        end
        else if (buffer_setup)
        begin
          buffer_setup <= 1'b0;
          buffer_left  <= {1'b0, link.wdata[3:0]} + 5'h01;
        end
        else if (buffer_left != 5'h00)
        begin
          buffer_left <= buffer_left - 5'h01;
          if (buffer_left == 5'h01)
            buffer_armed <= 1'b1;
        end
        else if (buffer_armed)
        begin
          // Only a confirm starts the write; anything else drops it
          buffer_armed <= 1'b0;
          if (link.wdata[7:0] == `CMD_CONFIRM && !vpp_bad && !prot_bad)
            busy_cnt <= `PROGRAM_BUSY_CYCLES;
        end
        else if (link.wdata[7:0] == `CMD_PROGRAM && busy_cnt == 8'h00)
          program_setup <= 1'b1;
        else if (link.wdata[7:0] == `CMD_BUFFER_PROGRAM &&
                 busy_cnt == 8'h00)
          buffer_setup <= 1'b1;
        else if (link.wdata[7:0] == `CMD_SUSPEND && busy_cnt != 8'h00)
          suspended <= 1'b1;
        else if (link.wdata[7:0] == `CMD_CONFIRM)
          suspended <= 1'b0;
      end
    end
  end

  // Error flags; set wins, clear refused while busy or suspended
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= 8'h80;
    else
    begin
      status[`SR_READY_BIT]   <= (busy_cnt == 8'h00) || suspended;
      status[`SR_SUSPEND_BIT] <= suspended;
      if (link.we && link.wdata[7:0] == `CMD_CLEAR_STATUS &&
          busy_cnt == 8'h00 && !suspended && !data_cycle)
      begin
        status[`SR_FAIL_BIT] <= 1'b0;
        status[`SR_VPP_BIT]  <= 1'b0;
        status[`SR_PROT_BIT] <= 1'b0;
      end
      if (link.we && (program_setup || buffer_armed))
      begin
        if (vpp_bad)
        begin
          status[`SR_VPP_BIT]  <= 1'b1;
          status[`SR_FAIL_BIT] <= 1'b1;
        end
        if (prot_bad)
        begin
          status[`SR_PROT_BIT] <= 1'b1;
          status[`SR_FAIL_BIT] <= 1'b1;
        end
      end
    end
  end

  // Read data, one cycle after re
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link.rdata  <= 16'h0000;
      link.rvalid <= 1'b0;
    end
    else
    begin
      link.rvalid <= link.re;
      unique case (mode)
        flash_query_pkg::mode_query:  link.rdata <= {8'h00, rom_byte};
        flash_query_pkg::mode_status: link.rdata <= {8'h00, status};
        default:                      link.rdata <= 16'hffff;
      endcase
    end
  end

  // Busy view
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      busy <= 1'b0;
    else
      busy <= busy_cnt != 8'h00;
  end
endmodule : flash_device_end

// >>> rtl/flash_host_end.sv
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "flash_query_regs.svh"
module flash_host_end
(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite write
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Link
  flash_link_if.host        link
);
  logic [2:0]  op;
  logic        go;
  logic [22:0] address;
  logic [15:0] data;
  logic [15:0] result;
  logic        error_seen;
  logic        done;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  flash_query_pkg::host_state_type state;
  logic        do_write;
  logic [3:0]  w_strb;
  logic [3:0]  count;
  logic [4:0]  words_left;
  logic [22:0] word_addr;

  // Target of the next buffered word; the first word lands on address
  assign word_addr = address + 23'(count) + 23'h000001 - 23'(words_left);

  // Write channel: take address and data in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_bresp   = 2'b00;

  // Register stores; a write to control with w_strb[0] set starts an operation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op      <= 3'h0;
      count   <= 4'h0;
      go      <= 1'b0;
      address <= 23'h000000;
      data    <= 16'h0000;
    end
    else
    begin
      go <= 1'b0;
      if (do_write && aw_addr == `REG_CONTROL && w_strb[0])
      begin
        op    <= w_data[2:0];
        count <= w_data[7:4];
        go <= 1'b1;
      end
      if (do_write && aw_addr == `REG_ADDRESS)
        address <= w_data[22:0];
      if (do_write && aw_addr == `REG_DATA)
        data <= w_data[15:0];
    end
  end

  // Read channel, one word per read, unmapped reads zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        `REG_CONTROL: s_axi_rdata <= {24'h0, count, 1'b0, op};
        `REG_ADDRESS: s_axi_rdata <= {9'h0, address};
        `REG_DATA:    s_axi_rdata <= {16'h0, result};
        `REG_STATUS:  s_axi_rdata <= {28'h0, 1'b0, error_seen,
                                      done, state != flash_query_pkg::host_idle};
        default:      s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp   = 2'b00;

  // Link sequencer: command cycle, optional data cycles, optional read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state      <= flash_query_pkg::host_idle;
      link.we    <= 1'b0;
      link.re    <= 1'b0;
      link.addr  <= 23'h000000;
      link.wdata <= 16'h0000;
      result     <= 16'h0000;
      done       <= 1'b0;
      error_seen <= 1'b0;
      words_left <= 5'h00;
    end
    else
    begin
      link.we <= 1'b0;
      link.re <= 1'b0;
      unique case (state)
        flash_query_pkg::host_idle:
          if (go && !(error_seen && (op == `OP_PROGRAM ||
                                     op == `OP_BUFFER)))
          begin
            done      <= 1'b0;
            link.we   <= 1'b1;
            link.addr <= address;
            state     <= flash_query_pkg::host_cmd;
            unique case (op)
              `OP_QUERY:   link.wdata <= {8'h00, `CMD_QUERY};
              `OP_PROGRAM: link.wdata <= {8'h00, `CMD_PROGRAM};
              `OP_BUFFER:  link.wdata <= {8'h00, `CMD_BUFFER_PROGRAM};
              `OP_CLEAR:   link.wdata <= {8'h00, `CMD_CLEAR_STATUS};
              `OP_SUSPEND: link.wdata <= {8'h00, `CMD_SUSPEND};
              `OP_RESUME:  link.wdata <= {8'h00, `CMD_CONFIRM};
              default:     link.wdata <= {8'h00, `CMD_READ_STATUS};
            endcase
          end
        flash_query_pkg::host_cmd:
          if (op == `OP_PROGRAM)
          begin
            link.we    <= 1'b1;
            link.wdata <= data;
            state      <= flash_query_pkg::host_data;
          end
          else if (op == `OP_BUFFER)
          begin
            // Count n goes first, then n plus one words follow
            link.we    <= 1'b1;
            link.wdata <= {12'h000, count};
            words_left <= {1'b0, count} + 5'h01;
            state      <= flash_query_pkg::host_data;
          end
          else if (op == `OP_QUERY || op == `OP_STATUS)
          begin
            link.re <= 1'b1;
            state   <= flash_query_pkg::host_read;
          end
          else
          begin
            if (op == `OP_CLEAR)
              error_seen <= 1'b0;
            state <= flash_query_pkg::host_done;
          end
        flash_query_pkg::host_data:
          if (op == `OP_BUFFER && words_left != 5'h00)
          begin
            link.we    <= 1'b1;
            link.wdata <= data;
            link.addr  <= word_addr;
            words_left <= words_left - 5'h01;
          end
          else if (op == `OP_BUFFER)
          begin
            link.we    <= 1'b1;
            link.wdata <= {8'h00, `CMD_CONFIRM};
            link.addr  <= address;
            state      <= flash_query_pkg::host_done;
          end
          else
            state <= flash_query_pkg::host_done;
        flash_query_pkg::host_read:
          if (link.rvalid)
          begin
            result <= link.rdata;
            if (op == `OP_STATUS && (link.rdata[`SR_PROT_BIT] ||
                link.rdata[`SR_VPP_BIT] || link.rdata[`SR_FAIL_BIT]))
              error_seen <= 1'b1;
            state <= flash_query_pkg::host_done;
          end
        flash_query_pkg::host_done:
        begin
          done  <= 1'b1;
          state <= flash_query_pkg::host_idle;
        end
        default:
          state <= flash_query_pkg::host_idle;
      endcase
    end
  end
endmodule : flash_host_end

// >>> test/flash_link_chk.sv
`timescale 1ns/100ps
`include "flash_query_regs.svh"
module flash_link_chk
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Link signals
  input wire logic        we,
  input wire logic        re,
  input wire logic [22:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Query command, then a read of one offset; bank bits ignored
  sequence s_q(logic [8:0] off);
    we && wdata[7:0] == `CMD_QUERY ##1 re && addr[8:0] == off;
  endsequence
  property p_answer;
    re |=> rvalid;
  endproperty
  property p_cause;
    rvalid |-> $past(re);
  endproperty
  // Bytes that are equal on both variants
  property p_ptr;
    s_q(9'h015) |=> rvalid && rdata[7:0] == 8'h0a;
  endproperty
  property p_conc;
    s_q(9'h130) |=> rvalid && rdata[7:0] == 8'h11;
  endproperty
  property p_other;
    s_q(9'h131) |=> rvalid && rdata[7:0] == 8'h00;
  endproperty
  property p_endur;
    s_q(9'h138) |=> rvalid && rdata[7:0] == 8'h64;
  endproperty
  property p_cell;
    s_q(9'h13a) |=> rvalid && rdata[7:0] == 8'h02;
  endproperty
  property p_cap;
    s_q(9'h13b) |=> rvalid && rdata[7:0] == 8'h03;
  endproperty
  a_answer: assert property (p_answer)
    else $error("read not answered");
  a_cause: assert property (p_cause)
    else $error("answer without read");
  a_ptr: assert property (p_ptr)
    else $error("bad table pointer");
  a_conc: assert property (p_conc)
    else $error("bad concurrency byte");
  a_other: assert property (p_other)
    else $error("bad other bank count");
  a_endur: assert property (p_endur)
    else $error("bad endurance");
  a_cell: assert property (p_cell)
    else $error("bad cell format");
  a_cap: assert property (p_cap)
    else $error("bad capability byte");
endmodule : flash_link_chk

// >>> test/testbench.sv
`timescale 1ns/100ps
`include "flash_query_regs.svh"
module testbench;
  // Query bytes from 12Eh to 151h per variant
  localparam logic [287:0] top_tab =
    {144'h0f00110000010f0000026400020301001100,
     144'h00020e000002640002030300800064000203};
  localparam logic [287:0] bot_tab =
    {144'h01001100000203008000640002030e000002,
     144'h640002030f00110000010f00000264000203};
  // Clock, reset, straps, device state
  logic        aclk, aresetn, top_boot, vpp_low, block_protected, busy;
  logic [7:0]  status;
  // AXI4-Lite
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  // Bench state
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n_we = 0;
  logic [22:0] last_addr;
  logic        saw_busy, clr_busy;
  logic [31:0] d, s;
  logic [7:0]  m;

  flash_link_if link();
  flash_device_end i_flash_device_end (.aclk, .aresetn, .link(link),
    .top_boot, .vpp_low, .block_protected, .busy, .status);
  flash_host_end i_flash_host_end (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .link(link));
  flash_link_chk i_flash_link_chk (.aclk(aclk), .aresetn(aresetn),
    .we(link.we), .re(link.re), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .rvalid(link.rvalid));

  // Clock
  always #5 aclk = ~aclk;

  // Timeout; busy seen; busy at the moment of a clear command
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (busy === 1'h1) saw_busy <= 1'h1;
    if (link.we && link.wdata[7:0] == `CMD_CLEAR_STATUS) clr_busy <= busy;
    if (link.we) n_we <= n_we + 1;
    if (link.we && link.wdata == 16'h1234) last_addr <= link.addr;
    if (cycles == 30000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d, failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk

  // Extra edge at the end so no handshake signal moves twice in a step
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : axi_rd

  // Poll done; a refused operation leaves done set from the previous one
  task automatic wait_done();
    logic [31:0] r;
    int n = 0;
    do
    begin
      axi_rd(`REG_STATUS, r);
      n++;
    end while (r[1] !== 1'h1 && n < 50);
  endtask : wait_done

  task automatic run_op(input logic [2:0] code);
    axi_wr(`REG_CONTROL, {29'h0, code});
    wait_done();
  endtask : run_op

  task automatic query(input logic [22:0] a, output logic [31:0] v);
    axi_wr(`REG_ADDRESS, {9'h0, a});
    run_op(`OP_QUERY);
    axi_rd(`REG_DATA, v);
  endtask : query

  task automatic stat(output logic [31:0] v);
    run_op(`OP_STATUS);
    axi_rd(`REG_DATA, v);
  endtask : stat

  task automatic prog(input logic [22:0] a);
    axi_wr(`REG_ADDRESS, {9'h0, a});
    axi_wr(`REG_DATA, 32'h1234);
    run_op(`OP_PROGRAM);
  endtask : prog

  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'h0 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_idle

  // Main sequence
  initial
  begin
    aclk = 1'h0;
    aresetn = 1'h0;
    top_boot = 1'h1;
    vpp_low = 1'h0;
    block_protected = 1'h0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    saw_busy = 1'h0;
    clr_busy = 1'h0;
    last_addr = 23'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(`REG_STATUS, s);
    chk(s, 32'h0);
    chk(status, 8'h80);
    $display("test reset done");
    // Whole region table; top variant carries bank bits in the address
    for (int v = 0; v < 2; v++)
    begin
      top_boot <= (v == 0);
      for (int i = 0; i < 36; i++)
      begin
        query({(v == 0) ? 14'h3e00 : 14'h0, 9'(9'h12e + i)}, d);
        chk(d[7:0], v ? bot_tab[287 - 8 * i -: 8]
                      : top_tab[287 - 8 * i -: 8]);
      end
    end
    query(23'h000015, d);
    chk(d[7:0], 8'h0a);
    query(23'h000016, d);
    chk(d[7:0], 8'h01);
    query(23'h00012d, d);
    chk(d[7:0], 8'h02);
    top_boot <= 1'h1;
    prog(23'h00012e);
    wait_idle();
    query(23'h00012e, d);
    chk(d[7:0], 8'h0f);
    $display("test query done");
    // Error flags: clear while busy, refusal, clear when idle
    for (int k = 0; k < 2; k++)
    begin
      m = k ? 8'h02 : 8'h08;
      vpp_low <= (k == 0);
      block_protected <= (k == 1);
      prog(23'h000200);
      wait_idle();
      vpp_low <= 1'h0;
      block_protected <= 1'h0;
      prog(23'h000200);
      run_op(`OP_CLEAR);
      chk(clr_busy, 1'h1);
      stat(d);
      chk(d[7:0] & m, m);
      axi_rd(`REG_STATUS, s);
      chk(s[2], 1'h1);
      wait_idle();
      saw_busy <= 1'h0;
      prog(23'h000200);
      repeat (20) @(posedge aclk);
      chk(saw_busy, 1'h0);
      run_op(`OP_CLEAR);
      stat(d);
      chk(d[7:0] & m, 8'h0);
      axi_rd(`REG_STATUS, s);
      chk(s[2], 1'h0);
      $display("test error %0d done", k);
    end
    // Buffered program: count 2, three words, then confirm
    axi_wr(`REG_ADDRESS, 32'h400);
    axi_wr(`REG_DATA, 32'h1234);
    saw_busy <= 1'h0;
    n_we <= 0;
    axi_wr(`REG_CONTROL, {24'h0, 4'h2, 1'h0, `OP_BUFFER});
    wait_done();
    wait_idle();
    chk(n_we, 32'h6);
    chk(last_addr, 32'h402);
    chk(saw_busy, 1'h1);
    $display("test buffer done");
    // Suspend, then status read before or after resume
    for (int j = 0; j < 2; j++)
    begin
      prog(23'h000300);
      run_op(`OP_SUSPEND);
      stat(d);
      chk(d[6], 1'h1);
      if (j == 0) stat(d);
      run_op(`OP_RESUME);
      if (j == 1) stat(d);
      wait_idle();
      stat(d);
      chk(d[7:6], 2'h2);
      $display("test suspend %0d done", j);
    end
    stop_test();
  end
endmodule : testbench
